//--- core/gcdfs_pin_mux.sv
/*
  Port C / port D pin function multiplexer with its APB register file.
  Assumes a zero-wait APB master on mclk, pads resolved outside from
  out/oe pairs, and peripheral enable bits supplied by the GPIO block.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: C6 select 0 gives adc_b_input_4/comparator plus; 1 gives pwm_output_2.
// R2: C0 select 0 gives adc_a_input_5/comparator minus; 1 gives fault input.
// R3: D3 bits 8:7 pick TMS, adc_b_input_11, timer 1, comparator1 output.
// R4: D2 bits 6:5 pick TCK, adc_a_input_4, comparator output; 11 reserved.
// R5: D1 bits 4:3 pick TDO, adc_b_input_10, timer 0, comparator2 output.
// R6: D0 bits 2:0 pick TDI, adc, slave select, timer input 2, cmp0.
// R7: Internal select fields choose the source of multi-source inputs.
// R8: Software keeps internal selects consistent with pin selects, enables.
// R9: A GPIO-sourced input must be fed by exactly one configured pin.
// R10: Software sets that pin's peripheral enable, giving peripheral control.
// R11: A GPIO-sourced input with no feeding pin gets a constant level.
// R12: Software should not change internal selects while peripheral runs.
// R13: Reserved bits read zero, ignore writes; reserved codes connect nothing.
module gcdfs_pin_mux
  import gcdfs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads, index 0 C0, 1 C6, 2 D0, 3 D1, 4 D2, 5 D3
  input wire logic [NUM_PINS-1:0] pinIn,
  output logic [NUM_PINS-1:0] pinOut,
  output logic [NUM_PINS-1:0] pinOe,
  output logic [NUM_PINS-1:0] analogConnect,
  // GPIO block
  input wire logic [NUM_PINS-1:0] gpioOut,
  input wire logic [NUM_PINS-1:0] gpioOe,
  input wire logic [NUM_PINS-1:0] pinPeripheralEnable,
  // Peripheral outputs toward pads
  input wire logic pwmOutput2,
  input wire logic jtagTdo,
  input wire logic jtagTdoOe,
  input wire logic timerChannel0Out,
  input wire logic timerChannel0Oe,
  input wire logic timerChannel1Out,
  input wire logic timerChannel1Oe,
  input wire logic spiSlaveSelectOut,
  input wire logic spiSlaveSelectOe,
  input wire logic comparator0Output,
  input wire logic comparator1Output,
  input wire logic comparator2Output,
  // Peripheral inputs from pads or on-chip comparators
  output logic jtagTms,
  output logic jtagTck,
  output logic jtagTdi,
  output logic timerChannel0In,
  output logic timerChannel1In,
  output logic timerInput2,
  output logic spiSlaveSelectInN,
  output logic pwmFaultInput0
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [15:0] portCSel_q;
  logic [15:0] portDSel_q;
  logic [15:0] internalSel_q;
  logic [31:0] prdata_q;
  logic [7:0] regIdx;
  logic wrStrobe;
  logic mapped;
  logic [15:0] byteMask;

  // Masks a 16-bit write by strobe and writable bits
  function automatic logic [15:0] mergeWrite(input logic [15:0] oldVal,
                                             input logic [15:0] newVal,
                                             input logic [15:0] lanes,
                                             input logic [15:0] fieldMask);
    logic [15:0] m;
    m = lanes & fieldMask;
    mergeWrite = (oldVal & ~m) | (newVal & m);
  endfunction

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero-wait slave; data is fetched in setup so prdata is a flop
  assign regIdx = {{IDX_LSB{1'b0}}, paddr[ADDR_W-1:IDX_LSB]};
  assign mapped = (regIdx == PORT_C_FUNCTION_SELECT_IDX) ||
                  (regIdx == PORT_D_FUNCTION_SELECT_IDX) ||
                  (regIdx == INTERNAL_SOURCE_SELECT_IDX);
  assign wrStrobe = psel && penable && pwrite && mapped;
  assign byteMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;  // Unmapped word
  assign prdata = prdata_q;

  // Read data capture during setup phase
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (regIdx)
        PORT_C_FUNCTION_SELECT_IDX: prdata_q <= {16'h0000, portCSel_q};
        PORT_D_FUNCTION_SELECT_IDX: prdata_q <= {16'h0000, portDSel_q};
        INTERNAL_SOURCE_SELECT_IDX: prdata_q <= {16'h0000, internalSel_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Port C select register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      portCSel_q <= PORT_C_RESET;
    end else if (wrStrobe && regIdx == PORT_C_FUNCTION_SELECT_IDX) begin
      portCSel_q <= mergeWrite(portCSel_q, pwdata[15:0], byteMask,
                               PORT_C_MASK);  // [R13]
    end
  end

  // Port D select register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      portDSel_q <= PORT_D_RESET;
    end else if (wrStrobe && regIdx == PORT_D_FUNCTION_SELECT_IDX) begin
      portDSel_q <= mergeWrite(portDSel_q, pwdata[15:0], byteMask,
                               PORT_D_MASK);  // [R13]
    end
  end

  // Internal source select register; changes take effect at once
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      internalSel_q <= INTERNAL_RESET;
    end else if (wrStrobe && regIdx == INTERNAL_SOURCE_SELECT_IDX) begin
      internalSel_q <= mergeWrite(internalSel_q, pwdata[15:0], byteMask,
                                  INTERNAL_MASK);  // [R7] [R13]
    end
  end

  // ----------------------------------------------------------------------
  // Per-pin select codes and slot tables
  // ----------------------------------------------------------------------
  logic [2:0] selCode [NUM_PINS];
  logic [NUM_SLOTS-1:0] slotOut [NUM_PINS];
  logic [NUM_SLOTS-1:0] slotOe [NUM_PINS];
  logic [NUM_SLOTS-1:0] slotHit [NUM_PINS];

  // Widens a one-bit pad field to the cell's three-bit code
  function automatic logic [2:0] oneBitCode(input logic fieldBit);
    oneBitCode = {2'h0, fieldBit};
  endfunction

  // Widens a two-bit pad field; shared by the three upper D pads
  function automatic logic [2:0] twoBitCode(input logic [15:0] regVal,
                                            input int lsb);
    twoBitCode = {1'b0, regVal[lsb +: D2B_SEL_W]};
  endfunction

  // Field extraction, narrower fields zero-extended
  always_comb begin
    selCode[PIN_C0] = oneBitCode(portCSel_q[C0_SEL_LSB]);  // [R2]
    selCode[PIN_C6] = oneBitCode(portCSel_q[C6_SEL_LSB]);  // [R1]
    selCode[PIN_D0] = portDSel_q[D0_SEL_LSB +: D0_SEL_W];  // [R6]
    selCode[PIN_D1] = twoBitCode(portDSel_q, D1_SEL_LSB);  // [R5]
    selCode[PIN_D2] = twoBitCode(portDSel_q, D2_SEL_LSB);  // [R4]
    selCode[PIN_D3] = twoBitCode(portDSel_q, D3_SEL_LSB);  // [R3]
  end

  // Outgoing functions per slot; unlisted slots stay undriven
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      slotOut[p] = '0;
      slotOe[p] = '0;  // Analog and reserved codes drive nothing [R13]
    end
    slotOut[PIN_C6][SLOT_DIGITAL_C] = pwmOutput2;  // [R1]
    slotOe[PIN_C6][SLOT_DIGITAL_C] = 1'b1;
    slotOut[PIN_D0][SLOT_D0_SS] = spiSlaveSelectOut;  // [R6]
    slotOe[PIN_D0][SLOT_D0_SS] = spiSlaveSelectOe;
    slotOut[PIN_D0][SLOT_D0_CMP0] = comparator0Output;
    slotOe[PIN_D0][SLOT_D0_CMP0] = 1'b1;
    slotOut[PIN_D1][SLOT_JTAG] = jtagTdo;  // [R5]
    slotOe[PIN_D1][SLOT_JTAG] = jtagTdoOe;
    slotOut[PIN_D1][SLOT_TIMER] = timerChannel0Out;
    slotOe[PIN_D1][SLOT_TIMER] = timerChannel0Oe;
    slotOut[PIN_D1][SLOT_CMP_D] = comparator2Output;
    slotOe[PIN_D1][SLOT_CMP_D] = 1'b1;
    slotOut[PIN_D2][SLOT_D2_CMP] = comparator1Output;  // [R4]
    slotOe[PIN_D2][SLOT_D2_CMP] = 1'b1;
    slotOut[PIN_D3][SLOT_TIMER] = timerChannel1Out;  // [R3]
    slotOe[PIN_D3][SLOT_TIMER] = timerChannel1Oe;
    slotOut[PIN_D3][SLOT_CMP_D] = comparator1Output;
    slotOe[PIN_D3][SLOT_CMP_D] = 1'b1;
  end

  // ----------------------------------------------------------------------
  // Pad cells
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_cell
    gcdfs_pin_cell u_cell (
      .selCode(selCode[p]),
      .perEnable(pinPeripheralEnable[p]),
      .slotOut(slotOut[p]),
      .slotOe(slotOe[p]),
      .gpioOut(gpioOut[p]),
      .gpioOe(gpioOe[p]),
      .pinOut(pinOut[p]),
      .pinOe(pinOe[p]),
      .slotHit(slotHit[p])
    );
  end

  // Analog switch enables
  always_comb begin
    analogConnect[PIN_C0] = slotHit[PIN_C0][SLOT_ANALOG_C];  // [R2]
    analogConnect[PIN_C6] = slotHit[PIN_C6][SLOT_ANALOG_C];  // [R1]
    analogConnect[PIN_D0] = slotHit[PIN_D0][SLOT_ANALOG_D];
    analogConnect[PIN_D1] = slotHit[PIN_D1][SLOT_ANALOG_D];
    analogConnect[PIN_D2] = slotHit[PIN_D2][SLOT_ANALOG_D];
    analogConnect[PIN_D3] = slotHit[PIN_D3][SLOT_ANALOG_D];
  end

  // ----------------------------------------------------------------------
  // Peripheral inputs
  // ----------------------------------------------------------------------
  // Picks the pad level when routed, else a safe constant
  function automatic logic padOrIdle(input logic hit, input logic level,
                                     input logic idle);
    padOrIdle = hit ? level : idle;
  endfunction

  logic faultFromPin;
  logic tin2FromPin;

  // Inputs fed only from pads; unfed ones sit at idle levels
  always_comb begin
    jtagTms = padOrIdle(slotHit[PIN_D3][SLOT_JTAG], pinIn[PIN_D3],
                        IDLE_TMS);  // [R3] [R11]
    jtagTck = padOrIdle(slotHit[PIN_D2][SLOT_JTAG], pinIn[PIN_D2],
                        IDLE_TCK);  // [R4] [R11]
    jtagTdi = padOrIdle(slotHit[PIN_D0][SLOT_JTAG], pinIn[PIN_D0],
                        IDLE_TDI);  // [R6] [R11]
    timerChannel0In = padOrIdle(slotHit[PIN_D1][SLOT_TIMER], pinIn[PIN_D1],
                                IDLE_TIMER);  // [R5] [R11]
    timerChannel1In = padOrIdle(slotHit[PIN_D3][SLOT_TIMER], pinIn[PIN_D3],
                                IDLE_TIMER);  // [R3] [R11]
    spiSlaveSelectInN = padOrIdle(slotHit[PIN_D0][SLOT_D0_SS],
                                  pinIn[PIN_D0], IDLE_SS_N);  // [R11]
    faultFromPin = padOrIdle(slotHit[PIN_C0][SLOT_DIGITAL_C],
                             pinIn[PIN_C0], IDLE_FAULT);  // [R2] [R11]
    tin2FromPin = padOrIdle(slotHit[PIN_D0][SLOT_D0_TIMER_INPUT_2], pinIn[PIN_D0],
                            IDLE_TIMER);  // [R6] [R11]
  end

  // Multi-source inputs: pad path or on-chip comparator
  always_comb begin
    pwmFaultInput0 = (internalSel_q[PWM_FAULT_INPUT_0_SRC_LSB] == SRC_ALT) ?
                     comparator2Output : faultFromPin;  // [R7]
    timerInput2 = (internalSel_q[TIMER_INPUT_2_SRC_LSB] == SRC_ALT) ?
                  comparator0Output : tin2FromPin;  // [R7]
  end

endmodule // gcdfs_pin_mux

`default_nettype wire

//--- core/gcdfs_pkg.sv
/*
  Constants for the port C / port D pin function select block: register
  indices, field layouts, select codes and the idle levels applied to
  peripheral inputs that no pin feeds.
  Assumes a 32-bit APB slave with byte addresses of four times the index.
*/
package gcdfs_pkg;

  // ----------------------------------------------------------------------
  // Register map (index, byte address is index times four)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PORT_C_FUNCTION_SELECT_IDX = 8'h0E;
  localparam logic [7:0] PORT_D_FUNCTION_SELECT_IDX = 8'h0F;
  localparam logic [7:0] INTERNAL_SOURCE_SELECT_IDX = 8'h10;
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------------
  localparam int C0_SEL_LSB = 0;
  localparam int C6_SEL_LSB = 1;
  localparam int D0_SEL_LSB = 0;
  localparam int D0_SEL_W = 3;
  localparam int D1_SEL_LSB = 3;
  localparam int D2_SEL_LSB = 5;
  localparam int D3_SEL_LSB = 7;
  localparam int D2B_SEL_W = 2;
  localparam int PWM_FAULT_INPUT_0_SRC_LSB = 0;
  localparam int TIMER_INPUT_2_SRC_LSB = 1;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [15:0] PORT_C_MASK = 16'h0003;
  localparam logic [15:0] PORT_D_MASK = 16'h01FF;
  localparam logic [15:0] INTERNAL_MASK = 16'h0003;
  localparam logic [15:0] PORT_C_RESET = 16'h0000;
  localparam logic [15:0] PORT_D_RESET = 16'h0000;
  localparam logic [15:0] INTERNAL_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Pin numbering inside the block and select slot codes
  // ----------------------------------------------------------------------
  localparam int NUM_PINS = 6;
  localparam int NUM_SLOTS = 8;
  localparam int PIN_C0 = 0;
  localparam int PIN_C6 = 1;
  localparam int PIN_D0 = 2;
  localparam int PIN_D1 = 3;
  localparam int PIN_D2 = 4;
  localparam int PIN_D3 = 5;

  localparam int SLOT_ANALOG_C = 0;  // C0 and C6 analog code
  localparam int SLOT_DIGITAL_C = 1; // C6 pwm_output_2, C0 pwm_fault_input_0
  localparam int SLOT_JTAG = 0;      // D0..D3 code 0
  localparam int SLOT_ANALOG_D = 1;
  localparam int SLOT_TIMER = 2;     // D1 T0, D3 T1
  localparam int SLOT_CMP_D = 3;     // D1 cmp2, D3 cmp1
  localparam int SLOT_D2_CMP = 2;
  localparam int SLOT_D0_SS = 2;
  localparam int SLOT_D0_TIMER_INPUT_2 = 3;
  localparam int SLOT_D0_CMP0 = 4;

  // Internal source choices
  localparam logic SRC_PIN = 1'b0;
  localparam logic SRC_ALT = 1'b1;

  // ----------------------------------------------------------------------
  // Constant levels for peripheral inputs with no pin feeding them
  // ----------------------------------------------------------------------
  localparam logic IDLE_TMS = 1'b1;
  localparam logic IDLE_TCK = 1'b0;
  localparam logic IDLE_TDI = 1'b1;
  localparam logic IDLE_SS_N = 1'b1;
  localparam logic IDLE_FAULT = 1'b0;
  localparam logic IDLE_TIMER = 1'b0;

endpackage

//--- core/gcdfs_pin_cell.sv
/*
  One pad's function router: picks a peripheral slot by select code, or
  hands the pad to GPIO when the peripheral enable is low.
  Assumes unused or reserved slots are presented with their enable low.
*/
`timescale 1ns/1ps
`default_nettype none

module gcdfs_pin_cell
  import gcdfs_pkg::*;
(
  input wire logic [2:0] selCode,
  input wire logic perEnable,
  input wire logic [NUM_SLOTS-1:0] slotOut,
  input wire logic [NUM_SLOTS-1:0] slotOe,
  input wire logic gpioOut,
  input wire logic gpioOe,
  output logic pinOut,
  output logic pinOe,
  output logic [NUM_SLOTS-1:0] slotHit
);

  // ----------------------------------------------------------------------
  // Slot routing
  // ----------------------------------------------------------------------
  // Peripheral owns the pad only while its enable bit is set
  always_comb begin
    slotHit = '0;
    pinOut = gpioOut;
    pinOe = gpioOe;
    if (perEnable) begin
      slotHit[selCode] = 1'b1;
      pinOut = slotOut[selCode];
      pinOe = slotOe[selCode];  // Reserved slot leaves pad undriven
    end
  end

endmodule // gcdfs_pin_cell

`default_nettype wire

//--- sim/gcdfs_mux_monitor.sv
/* Checker for the pin function multiplexer: shadows the select registers
   from APB writes and checks routing. Assumes binding to gcdfs_pin_mux. */
`timescale 1ns/1ps
`default_nettype none
module gcdfs_mux_monitor
  import gcdfs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_PINS-1:0] pinIn,
  input wire logic [NUM_PINS-1:0] pinOut,
  input wire logic [NUM_PINS-1:0] pinOe,
  input wire logic [NUM_PINS-1:0] analogConnect,
  input wire logic [NUM_PINS-1:0] pinPeripheralEnable,
  input wire logic pwmOutput2,
  input wire logic comparator0Output,
  input wire logic comparator1Output,
  input wire logic comparator2Output,
  input wire logic jtagTms,
  input wire logic timerInput2,
  input wire logic pwmFaultInput0
);
  logic [1:0] cSel_q;
  logic [7:0] dLo_q;
  logic dHi_q;
  logic [1:0] iSel_q;
  logic [8:0] d;
  logic wr;
  logic [NUM_PINS-1:0] pe;
  assign wr = psel && penable && pwrite && pready;
  assign pe = pinPeripheralEnable;
  assign d = {dHi_q, dLo_q};
  // Lane 0 shadow; reserved bits never stored
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cSel_q <= '0;
      dLo_q <= '0;
      iSel_q <= '0;
    end else if (wr && pstrb[0]) begin
      if (paddr == 8'h38) cSel_q <= pwdata[1:0];
      if (paddr == 8'h3c) dLo_q <= pwdata[7:0];
      if (paddr == 8'h40) iSel_q <= pwdata[1:0];
    end
  end
  // Lane 1 holds only the top bit of the D3 field
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) dHi_q <= 1'b0;
    else if (wr && pstrb[1] && paddr == 8'h3c) dHi_q <= pwdata[8];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Routing, read-back and unmapped-access properties
  // ----------------------------------------------------------------
  sequence rdD;
    psel && !penable && !pwrite && paddr == 8'h3c ##1 penable;
  endsequence
  c6_route_a: assert property (
    pe[1] |-> (cSel_q[1] ? pinOe[1] && pinOut[1] == pwmOutput2
      : analogConnect[1] && !pinOe[1])) else $error("c6 routing wrong");
  c0_analog_a: assert property (
    pe[0] && !cSel_q[0] |-> analogConnect[0] && !pinOe[0])
    else $error("c0 analog routing wrong");
  fault_src_a: assert property (
    pwmFaultInput0 == (iSel_q[0] ? comparator2Output
      : (pe[0] && cSel_q[0] ? pinIn[0] : IDLE_FAULT)))
    else $error("fault input source wrong");
  tms_src_a: assert property (
    jtagTms == (pe[5] && d[8:7] == 2'b00 ? pinIn[5] : IDLE_TMS))
    else $error("tms source wrong");
  d3_cmp_a: assert property (
    pe[5] && d[8:7] == 2'b11 |-> pinOe[5] && pinOut[5] == comparator1Output)
    else $error("d3 comparator routing wrong");
  d2_reserved_a: assert property (
    pe[4] && d[6:5] == 2'b11 |-> !pinOe[4] && !analogConnect[4])
    else $error("d2 reserved code connects");
  d1_analog_a: assert property (
    pe[3] |-> analogConnect[3] == (d[4:3] == 2'b01))
    else $error("d1 analog routing wrong");
  timer_input_2_src_a: assert property (
    timerInput2 == (iSel_q[1] ? comparator0Output
      : (pe[2] && d[2:0] == 3'd3 ? pinIn[2] : IDLE_TIMER)))
    else $error("timer input 2 source wrong");
  d0_reserved_a: assert property (
    pe[2] && d[2:0] > 3'd4 |-> !pinOe[2] && !analogConnect[2])
    else $error("d0 reserved code connects");
  read_back_a: assert property (
    rdD |-> prdata == {23'h0, d}) else $error("port d read back wrong");
  unmapped_a: assert property (
    psel && penable && paddr[7:2] > 6'h10 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule // gcdfs_mux_monitor

bind gcdfs_pin_mux gcdfs_mux_monitor mon (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
  .pinOut(pinOut), .pinOe(pinOe), .analogConnect(analogConnect),
  .pinPeripheralEnable(pinPeripheralEnable), .pwmOutput2(pwmOutput2),
  .comparator0Output(comparator0Output),
  .comparator1Output(comparator1Output),
  .comparator2Output(comparator2Output), .jtagTms(jtagTms),
  .timerInput2(timerInput2), .pwmFaultInput0(pwmFaultInput0));
`default_nettype wire

//--- sim/gpio_c_d_function_select_test.sv
/* Self-checking bench for the pin function multiplexer: APB traffic,
   code tables and random pad stimulus. Assumes the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module gpio_c_d_function_select_test
  import gcdfs_pkg::*;
;
  logic mclk = 1'b0, sysRst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00, a;
  logic [31:0] pwdata = 32'h0, prdata, rd, ex;
  logic [3:0] pstrb = 4'h0, st;
  logic [5:0] pinIn = 6'h0, gOut = 6'h0, gOe = 6'h0, pen = 6'h0;
  logic [5:0] pinOut, pinOe, anaC;
  logic [11:0] pv = 12'h0; // Peripheral outputs toward the pads
  logic tms, tck, tdi, t0In, t1In, timer_input_2, ssN, flt;
  logic [15:0] shC = 16'h0, shD = 16'h0, shI = 16'h0;
  int fails = 0, samples_checked = 0, n;
  gcdfs_pin_mux uut (
    .mclk(mclk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .analogConnect(anaC), .gpioOut(gOut),
    .gpioOe(gOe), .pinPeripheralEnable(pen), .pwmOutput2(pv[0]),
    .jtagTdo(pv[1]), .jtagTdoOe(pv[2]), .timerChannel0Out(pv[3]),
    .timerChannel0Oe(pv[4]), .timerChannel1Out(pv[5]),
    .timerChannel1Oe(pv[6]), .spiSlaveSelectOut(pv[7]),
    .spiSlaveSelectOe(pv[8]), .comparator0Output(pv[9]),
    .comparator1Output(pv[10]), .comparator2Output(pv[11]),
    .jtagTms(tms), .jtagTck(tck), .jtagTdi(tdi), .timerChannel0In(t0In),
    .timerChannel1In(t1In), .timerInput2(timer_input_2), .spiSlaveSelectInN(ssN),
    .pwmFaultInput0(flt));
  always #25 mclk = ~mclk;
  // Lane-merged register value, reserved bits dropped
  function automatic logic [15:0] merge(input logic [15:0] o, w,
      input logic [3:0] s, input logic [15:0] m);
    logic [15:0] ln;
    ln = {{8{s[1]}}, {8{s[0]}}};
    return ((o & ~ln) | (w & ln)) & m;
  endfunction
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] dt, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end else begin
      rd = prdata;
      err = pslverr;
    end
  endtask
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  initial begin
    void'($urandom(36282));
    repeat (12) @(posedge mclk);
    sysRst <= 1'b0;
    // Reset values of all three registers
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'h38 + 8'(4 * i), 32'h0, 4'h0);
      chk(rd === 32'h0, "reset value");
    end
    idle();
    $display("test reset values done");
    // Random writes, back-to-back read, random pads meanwhile
    repeat (80) begin
      a = 8'h38 + 8'(4 * ($urandom % 4));
      ex = $urandom;
      st = 4'($urandom);
      apb(1'b1, a, ex, st);
      if (a == 8'h38) shC = merge(shC, ex[15:0], st, PORT_C_MASK);
      if (a == 8'h3c) shD = merge(shD, ex[15:0], st, PORT_D_MASK);
      if (a == 8'h40) shI = merge(shI, ex[15:0], st, INTERNAL_MASK);
      apb(1'b0, a, 32'h0, 4'h0);
      ex = a == 8'h38 ? shC : a == 8'h3c ? shD : a == 8'h40 ? shI : 0;
      chk(rd === ex && err === (a == 8'h44), "read back");
      pinIn <= 6'($urandom);
      gOut <= 6'($urandom);
      gOe <= 6'($urandom);
      pen <= 6'($urandom);
      pv <= 12'($urandom);
      idle();
      chk((((pinOut ^ gOut) | (pinOe ^ gOe)) & ~pen) === 6'h0, "gpio");
    end
    $display("test random registers done");
    // Every D0 code with the D1, D2 and D3 codes alongside
    pen <= 6'h3f; // Every pad handed to its peripheral
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h3c, {23'h0, 2'(c), 2'(c), 2'(c), 3'(c)}, 4'h3);
      idle();
      chk(anaC[2] === (c == 1), "d0 analog");
      chk(c < 5 || pinOe[2] === 1'b0, "d0 reserved");
      chk(tdi === (c == 0 ? pinIn[2] : IDLE_TDI), "tdi");
      chk(ssN === (c == 2 ? pinIn[2] : IDLE_SS_N), "ss");
      chk(anaC[5] === ((c & 3) == 1), "d3 analog");
      chk((c & 3) != 2 || t1In === pinIn[5], "d3 timer");
      chk(tck === ((c&3) == 0 ? pinIn[4] : IDLE_TCK), "tck");
      chk((c&3) != 2 || pinOe[4] && pinOut[4] === pv[10], "d2 cmp");
      chk(t0In === ((c&3) == 2 ? pinIn[3] : IDLE_TIMER), "t0");
      chk((c&3) != 0 || pinOe[3] === pv[2] && pinOut[3] === pv[1], "tdo");
      chk(c != 4 || pinOe[2] && pinOut[2] === pv[9], "d0 cmp");
      chk(c != 2 || pinOe[2] === pv[8] && pinOut[2] === pv[7], "d0 ss");
    end
    apb(1'b1, 8'h38, 32'h0000_0002, 4'h1);
    apb(1'b1, 8'h40, 32'h0000_0003, 4'h1);
    idle();
    chk(pinOe[1] === 1'b1 && pinOut[1] === pv[0], "c6 pwm");
    chk(flt === pv[11] && timer_input_2 === pv[9], "alternate source");
    $display("test code tables done");
    // Second reset in mid-run clears the selects
    sysRst <= 1'b1;
    @(posedge mclk);
    sysRst <= 1'b0;
    apb(1'b0, 8'h3c, 32'h0, 4'h0);
    chk(rd === 32'h0, "second reset");
    idle();
    $display("test second reset done");
    end_sim();
  end
endmodule // gpio_c_d_function_select_test
`default_nettype wire
